// File: ccric_pkg.sv
// package: register map, fields, reset values and idle states for the clock ratio
package ccric_pkg;
    localparam logic [11:0] ADDR_CLOCK_DIVIDER = 12'h000;
    localparam logic [11:0] ADDR_IDLE_STATUS = 12'h004;
    localparam int RETURN_BIT = 15;
    localparam int RATIO_HI = 14;
    localparam int RATIO_LO = 12;
    localparam int SLOW_BIT = 11;
    localparam int POST_HI = 10;
    localparam int POST_LO = 8;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'hff00;
    localparam logic [2:0] RATIO_1_1 = 3'h0;
    localparam logic [7:0] POST_FULL = 8'h00;
    typedef enum logic [1:0] {
        CCRIC_RUN = 2'b00,
        CCRIC_ENTER = 2'b01,
        CCRIC_IDLE = 2'b10
    } ccric_state_t;
endpackage : ccric_pkg

// File: ccric_top.sv
// cpu clock ratio, rc postscaler and idle sequencing with an apb slave
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// - return_on_interrupt plus interrupt clears slowdown_enable, ratio to 1:1.
// - without return_on_interrupt, interrupts leave enable and ratio alone.
// - ratio field 000..111 selects cpu divide 1,2,4,...,128.
// - with slowdown_enable set the cpu clock is divided by the ratio.
// - with slowdown_enable clear the cpu runs at full rate.
// - rc postscaler field 000..111 selects divide 1,2,4,...,64,256.
// - idle entry withholds the cpu clock.
// - idle entry clears the watchdog count.
// - system clock keeps running during idle.
// - low-power oscillator runs in idle when watchdog or monitor is on.
// - idle ends on enabled interrupt, reset or watchdog time-out.
// - wake restores the cpu clock at once.
// - an interrupt during idle entry is deferred until entry completes.
// - enable at bit 11, ratio at bits 14:12, ratio defaults to 1:1.
// - return_on_interrupt at bit 15, default off.
// - peripherals keep full rate; only the cpu enable is thinned.
module ccric_top #(
    parameter int RATIO_W = 3,
    parameter int CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic idle_req,
    input wire logic irq_pending,
    input wire logic watchdog_timeout,
    input wire logic watchdog_enable,
    input wire logic failsafe_monitor_enable,
    input wire logic fast_osc_tick,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic watchdog_clear,
    output logic lp_osc_enable,
    output logic rc_clk_en,
    output logic idle_active,
    output logic wake_pulse
);
    logic [15:0] ctrl_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] rc_cnt_q;
    logic [RATIO_W:0] cfg_last_q;
    ccric_pkg::ccric_state_t state_q;
    logic slow_en;
    logic [RATIO_W-1:0] ratio;
    logic [RATIO_W-1:0] rcsel;
    logic [CNT_W-1:0] div_max;
    logic [CNT_W-1:0] rc_max;
    logic cfg_change;
    logic wr_ctrl;
    logic rd_hit;
    logic wake_ev;
    logic ret_hit;
    logic wake_held_q;
    logic wake_go;

    assign slow_en = ctrl_q[ccric_pkg::SLOW_BIT];
    assign ratio = ctrl_q[ccric_pkg::RATIO_HI:ccric_pkg::RATIO_LO];
    assign rcsel = ctrl_q[ccric_pkg::POST_HI:ccric_pkg::POST_LO];
    // 1:N ratio as terminal count N-1; disabled means every clock
    assign div_max = slow_en ? CNT_W'((1 << ratio) - 1)
                             : CNT_W'(0);
    // code 7 jumps to 256 rather than 128
    assign rc_max = (rcsel == 3'h7) ? CNT_W'(255)
                                    : CNT_W'((1 << rcsel) - 1);
    assign cfg_change = {slow_en, ratio} != cfg_last_q;
    assign wr_ctrl = psel && penable && pwrite
                     && paddr == ccric_pkg::ADDR_CLOCK_DIVIDER;
    assign rd_hit = paddr == ccric_pkg::ADDR_CLOCK_DIVIDER
                    || paddr == ccric_pkg::ADDR_IDLE_STATUS;
    assign ret_hit = irq_pending && ctrl_q[ccric_pkg::RETURN_BIT];
    assign wake_ev = irq_pending || watchdog_timeout;
    assign wake_go = wake_ev || wake_held_q;

    // control register; interrupt auto-return overrides a same-cycle write
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_q <= ccric_pkg::CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[15:0] & ccric_pkg::CTRL_WMASK;
            end
            if (ret_hit) begin
                ctrl_q[ccric_pkg::SLOW_BIT] <= 1'b0;
                ctrl_q[ccric_pkg::RATIO_HI:ccric_pkg::RATIO_LO]
                    <= ccric_pkg::RATIO_1_1;
            end
        end
    end

    // apb slave: zero wait states, unmapped address gives pslverr
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (paddr == ccric_pkg::ADDR_CLOCK_DIVIDER) begin
                    prdata <= {16'h0000, ctrl_q};
                end else if (paddr == ccric_pkg::ADDR_IDLE_STATUS) begin
                    prdata <= {30'h0000_0000, state_q};
                end
            end
        end
    end

    // doze counter; restarts on any change of enable or ratio
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_q <= '0;
            cfg_last_q <= '0;
        end else begin
            cfg_last_q <= {slow_en, ratio};
            if (cfg_change || cnt_q >= div_max) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + CNT_W'(1);
            end
        end
    end

    // rc postscaler divides the fast oscillator ticks
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rc_cnt_q <= '0;
            rc_clk_en <= 1'b0;
        end else begin
            rc_clk_en <= 1'b0;
            if (fast_osc_tick) begin
                if (rc_cnt_q >= rc_max) begin
                    rc_cnt_q <= '0;
                    rc_clk_en <= 1'b1;
                end else begin
                    rc_cnt_q <= rc_cnt_q + CNT_W'(1);
                end
            end
        end
    end

    // idle sequencer; a wake seen during entry is acted on once idle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_q <= ccric_pkg::CCRIC_RUN;
            watchdog_clear <= 1'b0;
            wake_pulse <= 1'b0;
            wake_held_q <= 1'b0;
        end else begin
            watchdog_clear <= 1'b0;
            wake_pulse <= 1'b0;
            case (state_q)
                ccric_pkg::CCRIC_RUN: begin
                    if (idle_req) begin
                        state_q <= ccric_pkg::CCRIC_ENTER;
                        watchdog_clear <= 1'b1;
                        // a wake that drops before idle must not be lost
                        wake_held_q <= wake_ev;
                    end
                end
                ccric_pkg::CCRIC_ENTER: begin
                    state_q <= ccric_pkg::CCRIC_IDLE;
                    if (wake_ev) begin
                        wake_held_q <= 1'b1;
                    end
                end
                ccric_pkg::CCRIC_IDLE: begin
                    if (wake_go) begin
                        state_q <= ccric_pkg::CCRIC_RUN;
                        wake_pulse <= 1'b1;
                        wake_held_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ccric_pkg::CCRIC_RUN;
                    wake_held_q <= 1'b0;
                end
            endcase
        end
    end

    // clock enables; the cpu enable is gated, never the system clock
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            idle_active <= 1'b0;
            lp_osc_enable <= 1'b0;
        end else begin
            periph_clk_en <= 1'b1;
            idle_active <= state_q == ccric_pkg::CCRIC_ENTER
                           || (state_q == ccric_pkg::CCRIC_IDLE && !wake_go)
                           || (state_q == ccric_pkg::CCRIC_RUN && idle_req);
            // withheld from the request edge; restored on the wake edge itself
            cpu_clk_en <= !idle_req && (state_q == ccric_pkg::CCRIC_RUN
                          || (state_q == ccric_pkg::CCRIC_IDLE && wake_go))
                          && (cnt_q >= div_max || cfg_change);
            lp_osc_enable <= watchdog_enable || failsafe_monitor_enable;
        end
    end

    property p_return_clears;
        @(posedge clk_sys) disable iff (!rstn)
        irq_pending && ctrl_q[15] |=> !ctrl_q[11] && ctrl_q[14:12] == 3'h0;
    endproperty
    a_return_clears: assert property (p_return_clears)
        else $error("return on interrupt did not restore full speed");

    property p_no_return_keeps;
        @(posedge clk_sys) disable iff (!rstn)
        irq_pending && !ctrl_q[15] && !wr_ctrl |=> $stable(ctrl_q);
    endproperty
    a_no_return_keeps: assert property (p_no_return_keeps)
        else $error("interrupt changed ratio without return on interrupt");

    property p_full_rate;
        @(posedge clk_sys) disable iff (!rstn)
        !slow_en && state_q == ccric_pkg::CCRIC_RUN && !idle_req
            |=> cpu_clk_en;
    endproperty
    a_full_rate: assert property (p_full_rate)
        else $error("cpu not at full rate with slowdown off");

    property p_div2;
        @(posedge clk_sys) disable iff (!rstn)
        cpu_clk_en && slow_en && ratio == 3'h1 && $stable(ctrl_q)
            && state_q == ccric_pkg::CCRIC_RUN |=> !cpu_clk_en;
    endproperty
    a_div2: assert property (p_div2)
        else $error("1:2 ratio gave back to back cpu enables");

    sequence s_enter;
        state_q == ccric_pkg::CCRIC_RUN && idle_req;
    endsequence
    property p_idle_entry;
        @(posedge clk_sys) disable iff (!rstn)
        s_enter |=> watchdog_clear && !cpu_clk_en ##1 !cpu_clk_en;
    endproperty
    a_idle_entry: assert property (p_idle_entry)
        else $error("idle entry did not stop cpu and clear watchdog");

    property p_wake;
        @(posedge clk_sys) disable iff (!rstn)
        state_q == ccric_pkg::CCRIC_IDLE && watchdog_timeout
            |=> state_q == ccric_pkg::CCRIC_RUN && wake_pulse;
    endproperty
    a_wake: assert property (p_wake)
        else $error("watchdog time-out did not wake from idle");

    property p_defer;
        @(posedge clk_sys) disable iff (!rstn)
        state_q == ccric_pkg::CCRIC_ENTER |=> state_q == ccric_pkg::CCRIC_IDLE;
    endproperty
    a_defer: assert property (p_defer)
        else $error("idle entry did not complete before wake");

    property p_lp_osc;
        @(posedge clk_sys) disable iff (!rstn)
        watchdog_enable |=> lp_osc_enable;
    endproperty
    a_lp_osc: assert property (p_lp_osc)
        else $error("low power oscillator off with watchdog on");

    property p_periph;
        @(posedge clk_sys) disable iff (!rstn)
        idle_active |-> periph_clk_en;
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral clock stopped");

    sequence s_coincide;
        state_q == ccric_pkg::CCRIC_RUN && idle_req && wake_ev;
    endsequence
    property p_coincide_wake;
        @(posedge clk_sys) disable iff (!rstn)
        s_coincide |=> ##2 state_q == ccric_pkg::CCRIC_RUN && wake_pulse;
    endproperty
    a_coincide_wake: assert property (p_coincide_wake)
        else $error("wake coinciding with idle entry was lost");

    property p_clear_once;
        @(posedge clk_sys) disable iff (!rstn)
        watchdog_clear |=> !watchdog_clear;
    endproperty
    a_clear_once: assert property (p_clear_once)
        else $error("watchdog clear held longer than one cycle");

    property p_lp_off;
        @(posedge clk_sys) disable iff (!rstn)
        !watchdog_enable && !failsafe_monitor_enable |=> !lp_osc_enable;
    endproperty
    a_lp_off: assert property (p_lp_off)
        else $error("low power oscillator on with watchdog and monitor off");

    property p_idle_hold;
        @(posedge clk_sys) disable iff (!rstn)
        state_q == ccric_pkg::CCRIC_IDLE && !wake_go
            |=> state_q == ccric_pkg::CCRIC_IDLE && !cpu_clk_en;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("cpu clock or state moved in idle without a wake");
endmodule : ccric_top

// File: ccric_cpu_model.sv
// cpu core, interrupt source and watchdog stand-in for the clock block
`timescale 1ns/1ns
module ccric_cpu_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic go_idle,
    input wire logic go_irq,
    input wire logic go_timeout,
    input wire logic wake_pulse,
    output logic idle_req,
    output logic irq_pending,
    output logic watchdog_timeout,
    output logic stall_q
);
    // one-cycle idle request, then the core stalls until wake
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            idle_req <= 1'b0;
            stall_q <= 1'b0;
        end else begin
            idle_req <= go_idle & !stall_q;
            if (wake_pulse) begin
                stall_q <= 1'b0;
            end else if (go_idle) begin
                stall_q <= 1'b1;
            end
        end
    end
    // events are registered so they change just after an edge
    always_ff @(posedge clk_sys) begin
        irq_pending <= rstn & go_irq;
        watchdog_timeout <= rstn & go_timeout;
    end
endmodule : ccric_cpu_model

// File: tb_cpu_clock_ratio_idle_control.sv
// self-checking bench for the cpu clock ratio and idle control block
`timescale 1ns/1ns
module tb_cpu_clock_ratio_idle_control;
    logic clk_sys = 0;
    logic rstn = 0;
    logic psel = 0, penable = 0, pwrite = 0, go_idle = 0, go_irq = 0;
    logic go_timeout = 0, watchdog_enable = 0, failsafe_monitor_enable = 0;
    logic fast_osc_tick = 0, err, h_clr, h_wake, h_run;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, n;
    logic pready, pslverr, idle_req, irq_pending, watchdog_timeout, stall;
    logic cpu_clk_en, periph_clk_en, watchdog_clear, lp_osc_enable;
    logic rc_clk_en, idle_active, wake_pulse;
    int mismatches = 0, samples_checked = 0, cyc = 0;
    always #50 clk_sys = ~clk_sys;
    ccric_top ccric_top_inst (.clk_sys, .rstn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .idle_req, .irq_pending,
        .watchdog_timeout, .watchdog_enable, .failsafe_monitor_enable,
        .fast_osc_tick, .cpu_clk_en, .periph_clk_en, .watchdog_clear,
        .lp_osc_enable, .rc_clk_en, .idle_active, .wake_pulse);
    ccric_cpu_model ccric_cpu_model_inst (.clk_sys, .rstn, .go_idle,
        .go_irq, .go_timeout, .wake_pulse, .idle_req, .irq_pending,
        .watchdog_timeout, .stall_q(stall));
    task automatic results;
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    // a hung handshake must not stall the run forever
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 15000) begin
            mismatches++;
            results;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        // no assumed wait count; only the bench timeout ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic cnt(input int m, input logic rc);
        n = 0;
        repeat (m) begin
            @(negedge clk_sys);
            n += rc ? rc_clk_en : cpu_clk_en;
        end
    endtask : cnt
    task automatic watch(input int m);
        {h_clr, h_wake, h_run} = 3'h0;
        repeat (m) begin
            @(negedge clk_sys);
            h_clr |= watchdog_clear;
            h_wake |= wake_pulse;
            h_run |= !idle_active;
        end
    endtask : watch
    task automatic t_regs;
        apb(0, 12'h000, 0);
        chk(rd, 32'h0000_0000);
        apb(1, 12'h000, 32'hffff_ffff);
        apb(0, 12'h000, 0);
        chk(rd, 32'h0000_ff00);
        apb(0, 12'h008, 0);
        chk(err, 1);
        apb(1, 12'h000, 0);
    endtask : t_regs
    task automatic t_ratio;
        for (int r = 0; r < 8; r++) begin
            apb(1, 12'h000, 32'h0000_0800 | (r << 12));
            repeat (4) @(posedge clk_sys);
            cnt(256, 0);
            chk(n, 256 >> r);
            chk(periph_clk_en, 1);
        end
        apb(1, 12'h000, 32'h0000_7000);
        repeat (4) @(posedge clk_sys);
        cnt(256, 0);
        chk(n, 256);
    endtask : t_ratio
    task automatic t_rc;
        @(posedge clk_sys);
        fast_osc_tick <= 1;
        for (int s = 0; s < 8; s++) begin
            apb(1, 12'h000, s << 8);
            repeat (4) @(posedge clk_sys);
            cnt(512, 1);
            chk(n, (s == 7) ? 2 : 512 >> s);
        end
    endtask : t_rc
    task automatic irq;
        go_irq <= 1;
        @(posedge clk_sys);
        go_irq <= 0;
        repeat (3) @(posedge clk_sys);
    endtask : irq
    task automatic t_roi;
        apb(1, 12'h000, 32'h0000_3800);
        irq;
        apb(0, 12'h000, 0);
        chk(rd, 32'h0000_3800);
        apb(1, 12'h000, 32'h0000_b800);
        irq;
        apb(0, 12'h000, 0);
        chk(rd, 32'h0000_8000);
        cnt(64, 0);
        chk(n, 64);
        apb(1, 12'h000, 0);
    endtask : t_roi
    // kind: 0 irq wake, 1 watchdog wake, 2 reset wake, 3 coincident irq
    task automatic t_idle(input int kind);
        @(posedge clk_sys);
        watchdog_enable <= (kind != 1);
        failsafe_monitor_enable <= (kind == 1);
        go_idle <= 1;
        go_irq <= (kind == 3);
        @(posedge clk_sys);
        go_idle <= 0;
        go_irq <= 0;
        watch(kind == 3 ? 10 : 6);
        chk(h_clr, 1);
        if (kind == 3) begin
            chk(h_wake, 1);
        end else begin
            cnt(20, 0);
            chk(n, 0);
            chk({idle_active, periph_clk_en, lp_osc_enable}, 7);
            chk(stall, 1);
            @(posedge clk_sys);
            go_irq <= (kind == 0);
            go_timeout <= (kind == 1);
            rstn <= (kind != 2);
            repeat (2) @(posedge clk_sys);
            {go_irq, go_timeout, rstn} <= 3'h1;
            watch(6);
            chk(h_run, 1);
            chk(h_wake, kind != 2);
        end
        cnt(8, 0);
        chk(n, 8);
    endtask : t_idle
    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1;
        t_regs;
        t_ratio;
        t_rc;
        t_roi;
        for (int k = 0; k < 4; k++) t_idle(k);
        results;
    end
endmodule : tb_cpu_clock_ratio_idle_control
